// ### hw/bwr_defines.svh
`ifndef BWR_DEFINES_SVH
`define BWR_DEFINES_SVH

// ****************************************
// register addresses (protocol address = number - 1)
// ****************************************
`define BWR_ADDR_SETPOINT      16'h0000
`define BWR_ADDR_OVERRIDE      16'h0001
`define BWR_ADDR_FLOW_SEL_LO   16'h000c
`define BWR_ADDR_FAULT_STATUS  16'h0068
`define BWR_ADDR_FAIL_SAFE     16'h006c
`define BWR_ADDR_WD_TIMEOUT    16'h006d
`define BWR_ADDR_FLOW_M3H      16'h006e
`define BWR_ADDR_FLOW_SEL_HI   16'h0071
`define BWR_ADDR_CTRL_MODE     16'h0074
`define BWR_ADDR_UNIT_SEL      16'h0075
`define BWR_ADDR_SP_ORIGIN     16'h0076

// ****************************************
// fields, ranges and reset values
// ****************************************
`define BWR_WD_FAULT_BIT       10
`define BWR_FAIL_SAFE_MAX      16'h2710
`define BWR_WD_TIMEOUT_MAX     16'h0e10
`define BWR_WD_DEFAULT_SEC     16'h0078
`define BWR_RST_FAIL_SAFE      16'h0000
`define BWR_RST_WD_TIMEOUT     16'h0000

// ****************************************
// timing
// ****************************************
`define BWR_SECOND_NS          1000000000
`define BWR_CLK_PERIOD_NS      5
`define BWR_TICKS_PER_SEC      (`BWR_SECOND_NS / `BWR_CLK_PERIOD_NS)

`endif

// ### hw/bwr_pkg.sv
package bwr_pkg;

  // flow unit codes
  typedef enum logic [15:0] {
    BWR_UNIT_M3H = 16'h0001,
    BWR_UNIT_LPS = 16'h0002,
    BWR_UNIT_CFM = 16'h0006
  } bwr_unit_t;

  // setpoint origin codes
  typedef enum logic [0:0] {
    BWR_SRC_ANALOG = 1'b0,
    BWR_SRC_BUS    = 1'b1
  } bwr_src_t;

  // control mode codes
  typedef enum logic [0:0] {
    BWR_MODE_POSITION = 1'b0,
    BWR_MODE_FLOW     = 1'b1
  } bwr_mode_t;

endpackage

// ### hw/bwr_watchdog_bank.sv
`timescale 1ns/1ps
`include "bwr_defines.svh"

module bwr_watchdog_bank #(
  parameter int P_TICKS_PER_SEC = `BWR_TICKS_PER_SEC
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // register access from the frame decoder
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire logic [15:0]          i_reg_addr,
  input  wire logic [15:0]          i_reg_wdata,
  output logic      [15:0]          o_reg_rdata,
  output logic                      o_reg_ack,
  output logic                      o_reg_err,
  // plant values
  input  wire logic [31:0]          i_nominal_flow_sel,
  input  wire logic [15:0]          i_nominal_flow_m3h,
  input  wire bwr_pkg::bwr_mode_t   i_control_mode,
  input  wire logic [15:0]          i_other_status,
  input  wire logic [15:0]          i_analog_setpoint,
  input  wire logic [15:0]          i_bus_setpoint,
  // actuator side
  output logic      [15:0]          o_actuator_target,
  output logic                      o_bus_fail,
  output bwr_pkg::bwr_unit_t        o_chosen_flow_unit
);
  import bwr_pkg::*;

  // a prescaler needs at least one tick per second, refused at elaboration
  if (P_TICKS_PER_SEC < 1) begin : g_bad_ticks
    $error("P_TICKS_PER_SEC must be at least 1");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0] fail_safe;
    logic [15:0] timeout;
    logic        timeout_written;
    bwr_unit_t   unit;
    bwr_src_t    source;
    bwr_mode_t   mode;
    logic [31:0] presc;
    logic [15:0] secs;
    logic        fault;
    logic [15:0] target;
    logic [15:0] rdata;
    logic        ack;
    logic        err;
  } bwr_state_t;

  bwr_state_t st;
  bwr_state_t next_st;
  logic [15:0] eff_timeout;
  logic        renew;
  logic        active;
  logic        mapped;

  // effective timeout: untouched zero falls back to the default while a fail-safe is set
  always_comb begin
    if (!st.timeout_written && st.fail_safe != 16'h0000) begin
      eff_timeout = `BWR_WD_DEFAULT_SEC;
    end else begin
      eff_timeout = st.timeout;
    end
  end

  // renewal is any write to the setpoint or override address, answered by another bank
  assign renew  = i_reg_wr && (i_reg_addr == `BWR_ADDR_SETPOINT || i_reg_addr == `BWR_ADDR_OVERRIDE);
  // analog origin is hybrid mode; zero timeout disables detection
  assign active = (st.source == BWR_SRC_BUS) && (eff_timeout != 16'h0000);

  // address decode of this slice
  always_comb begin
    unique case (i_reg_addr)
      `BWR_ADDR_FLOW_SEL_LO, `BWR_ADDR_FAULT_STATUS, `BWR_ADDR_FAIL_SAFE, `BWR_ADDR_WD_TIMEOUT,
      `BWR_ADDR_FLOW_M3H, `BWR_ADDR_FLOW_SEL_HI, `BWR_ADDR_CTRL_MODE, `BWR_ADDR_UNIT_SEL,
      `BWR_ADDR_SP_ORIGIN: mapped = 1'b1;
      default:             mapped = 1'b0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st       = st;
    next_st.ack   = 1'b0;
    next_st.err   = 1'b0;
    next_st.mode  = i_control_mode;

    // watchdog: a renewal or an inactive supervisor ends the fault at once
    if (renew || !active) begin
      next_st.presc = 32'h0;
      next_st.secs  = 16'h0;
      next_st.fault = 1'b0;
    end else if (!st.fault) begin
      if (st.presc == 32'(P_TICKS_PER_SEC - 1)) begin
        next_st.presc = 32'h0;
        next_st.secs  = st.secs + 16'h0001;
        if (st.secs + 16'h0001 >= eff_timeout) begin
          next_st.fault = 1'b1;
        end
      end else begin
        next_st.presc = st.presc + 32'h1;
      end
    end

    // register access; only this slice's addresses answer
    if ((i_reg_wr || i_reg_rd) && mapped) begin
      next_st.ack = 1'b1;
      if (i_reg_wr) begin
        unique case (i_reg_addr)
          `BWR_ADDR_FAIL_SAFE: begin
            // full mechanical range, independent of min/max
            if (i_reg_wdata <= `BWR_FAIL_SAFE_MAX) next_st.fail_safe = i_reg_wdata;
            else next_st.err = 1'b1;
          end
          `BWR_ADDR_WD_TIMEOUT: begin
            if (i_reg_wdata <= `BWR_WD_TIMEOUT_MAX) begin
              next_st.timeout         = i_reg_wdata;
              next_st.timeout_written = 1'b1;
            end else begin
              next_st.err = 1'b1;
            end
          end
          `BWR_ADDR_UNIT_SEL: begin
            unique case (i_reg_wdata)
              BWR_UNIT_M3H, BWR_UNIT_LPS, BWR_UNIT_CFM: next_st.unit = bwr_unit_t'(i_reg_wdata);
              default: next_st.err = 1'b1;
            endcase
          end
          `BWR_ADDR_SP_ORIGIN: begin
            if (i_reg_wdata <= 16'h0001) next_st.source = bwr_src_t'(i_reg_wdata[0]);
            else next_st.err = 1'b1;
          end
          default: next_st.err = 1'b1;  // read-only registers refuse writes
        endcase
      end else begin
        unique case (i_reg_addr)
          `BWR_ADDR_FLOW_SEL_LO:  next_st.rdata = i_nominal_flow_sel[15:0];
          `BWR_ADDR_FLOW_SEL_HI:  next_st.rdata = i_nominal_flow_sel[31:16];
          `BWR_ADDR_FLOW_M3H:     next_st.rdata = i_nominal_flow_m3h;
          `BWR_ADDR_FAIL_SAFE:    next_st.rdata = st.fail_safe;
          `BWR_ADDR_WD_TIMEOUT:   next_st.rdata = eff_timeout;
          `BWR_ADDR_CTRL_MODE:    next_st.rdata = {15'h0000, st.mode};
          `BWR_ADDR_UNIT_SEL:     next_st.rdata = st.unit;
          `BWR_ADDR_SP_ORIGIN:    next_st.rdata = {15'h0000, st.source};
          `BWR_ADDR_FAULT_STATUS: begin
            next_st.rdata = i_other_status;
            next_st.rdata[`BWR_WD_FAULT_BIT] = st.fault;
          end
          default:                next_st.rdata = 16'h0000;
        endcase
      end
    end

    // actuator target: fail-safe wins over either setpoint source
    if (next_st.fault) begin
      next_st.target = next_st.fail_safe;
    end else if (next_st.source == BWR_SRC_ANALOG) begin
      next_st.target = i_analog_setpoint;
    end else begin
      next_st.target = i_bus_setpoint;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st                 <= '0;
      st.fail_safe       <= `BWR_RST_FAIL_SAFE;
      st.timeout         <= `BWR_RST_WD_TIMEOUT;
      st.unit            <= BWR_UNIT_M3H;
      st.source          <= BWR_SRC_BUS;
      st.mode            <= BWR_MODE_FLOW;
    end else begin
      st <= next_st;
    end
  end

  assign o_reg_rdata        = st.rdata;
  assign o_reg_ack          = st.ack;
  assign o_reg_err          = st.err;
  assign o_actuator_target  = st.target;
  assign o_bus_fail         = st.fault;
  assign o_chosen_flow_unit = st.unit;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_hybrid_no_fault: assert property (st.source == BWR_SRC_ANALOG |=> !o_bus_fail)
    else $error("bus fail raised in hybrid mode");
  chk_fail_target: assert property ($rose(o_bus_fail) |-> o_actuator_target == st.fail_safe)
    else $error("target not fail-safe on bus fail");
  chk_renew_clears: assert property (renew |=> !o_bus_fail)
    else $error("renewal did not clear bus fail");
  chk_zero_disables: assert property (st.timeout_written && st.timeout == 16'h0000 |=> !o_bus_fail)
    else $error("zero timeout still detects");
  chk_default_timeout: assert property (!st.timeout_written && st.fail_safe != 16'h0000
      |-> eff_timeout == `BWR_WD_DEFAULT_SEC)
    else $error("default timeout not 120");
  chk_unit_legal: assert property (o_chosen_flow_unit inside {BWR_UNIT_M3H, BWR_UNIT_LPS, BWR_UNIT_CFM})
    else $error("illegal flow unit");
  chk_status_bit: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == `BWR_ADDR_FAULT_STATUS
      |=> o_reg_ack && o_reg_rdata[10] == $past(o_bus_fail))
    else $error("status bit 10 does not show bus fail");
  chk_low_word: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == `BWR_ADDR_FLOW_SEL_LO
      |=> o_reg_rdata == $past(i_nominal_flow_sel[15:0]))
    else $error("low word mismatch");
  chk_mode_ro: assert property (i_reg_wr && i_reg_addr == `BWR_ADDR_CTRL_MODE |=> o_reg_err)
    else $error("control mode write not refused");
  chk_failsafe_range: assert property (st.fail_safe <= `BWR_FAIL_SAFE_MAX)
    else $error("fail-safe out of range");
  chk_fault_timing: assert property ($rose(o_bus_fail) |-> $past(st.secs) + 16'h0001 >= $past(eff_timeout))
    else $error("bus fail before timeout");

endmodule // bwr_watchdog_bank

// ### testbench/bwr_master_model.sv
`timescale 1ns/1ps
// ****************************************
// bus master model: one register request at a time
// ****************************************
module bwr_master_model (
  // clock
  input  wire logic        i_clk,
  // request side
  output logic             o_wr,
  output logic             o_rd,
  output logic [15:0]      o_addr,
  output logic [15:0]      o_wdata,
  // answer side
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_ack,
  input  wire logic        i_err
);
  // idle lines start with a pattern, never a plausible request
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 16'h5a5a;
    o_wdata = 16'ha5a5;
  end

  // request held over one taking edge, answer sampled 1 ns after that same edge
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic k, output logic e, output logic [15:0] q);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= !w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;  // released lines never keep the last value
    o_wdata <= ~d;
    #1;
    k = i_ack;
    e = i_err;
    q = i_rdata;
  endtask
endmodule // bwr_master_model

// ### testbench/bwr_watchdog_bank_test.sv
`timescale 1ns/1ps
module bwr_watchdog_bank_test;
  import bwr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr, rd, ack, err, bf;
  logic [15:0] addr, wd, rdat, m3h, oth, asp, bsp, tgt;
  logic [31:0] flow, rng = 32'he662;
  bwr_mode_t mode = BWR_MODE_FLOW;
  bwr_unit_t unit;
  int fails = 0, total_checks = 0, n;
  logic [15:0] codes [4] = '{16'h1, 16'h2, 16'h6, 16'h3};
  logic k, e;
  logic [15:0] q;

  always #2.5 clk = ~clk;

  // four ticks a second keeps the timeouts short
  bwr_watchdog_bank #(.P_TICKS_PER_SEC(4)) DUT (.i_clk(clk), .i_rst(rst), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_ack(ack),
    .o_reg_err(err), .i_nominal_flow_sel(flow), .i_nominal_flow_m3h(m3h), .i_control_mode(mode),
    .i_other_status(oth), .i_analog_setpoint(asp), .i_bus_setpoint(bsp),
    .o_actuator_target(tgt), .o_bus_fail(bf), .o_chosen_flow_unit(unit));
  bwr_master_model u_m (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wd),
    .i_rdata(rdat), .i_ack(ack), .i_err(err));

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // write and compare the answer flags
  task automatic wreg(input logic [15:0] a, input logic [15:0] d, input logic ee);
    u_m.xfer(1'b1, a, d, k, e, q);
    chk("wr ack", {31'h0, k}, 32'h1);
    chk("wr err", {31'h0, e}, {31'h0, ee});
  endtask

  task automatic rreg(input logic [15:0] a, input logic [15:0] x);
    u_m.xfer(1'b0, a, 16'h0, k, e, q);
    chk("rd ack", {31'h0, k}, 32'h1);
    chk("rd data", {16'h0, q}, {16'h0, x});
  endtask

  // bounded wait for the fail flag; a run-out ends the run
  task automatic wait_bf(input logic want, input int lim);
    for (n = 0; n < lim && bf !== want; n++) @(posedge clk) #1;
    if (bf !== want) begin
      chk("bus fail wait", {31'h0, bf}, {31'h0, want});
      complete_run();
    end
  endtask

  initial begin
    flow <= xs();
    m3h <= xs();
    oth <= xs();
    asp <= xs();
    bsp <= xs();
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rreg(16'h6c, 16'h0);
    rreg(16'h6d, 16'h0);
    rreg(16'h74, 16'h1);
    rreg(16'h75, 16'h1);
    rreg(16'h76, 16'h1);
    chk("target bus", tgt, bsp);
    wreg(16'h74, 16'h0, 1'b1);
    mode <= BWR_MODE_POSITION;
    rreg(16'h74, 16'h0);
    foreach (codes[i]) wreg(16'h75, codes[i], codes[i] == 16'h3);
    chk("unit", unit, 16'h6);
    rreg(16'h0c, flow[15:0]);
    rreg(16'h71, flow[31:16]);
    rreg(16'h6e, m3h);
    u_m.xfer(1'b0, 16'h0050, 16'h0, k, e, q);
    chk("unmapped ack", {31'h0, k}, 32'h0);
    wreg(16'h6c, 16'h2711, 1'b1);
    wreg(16'h6c, 16'h2710, 1'b0);
    rreg(16'h6d, 16'h0078);
    wreg(16'h6d, 16'h0001, 1'b0);
    u_m.xfer(1'b1, 16'h0000, xs(), k, e, q);
    wait_bf(1'b0, 3);
    wait_bf(1'b1, 12);
    chk("expiry cycles", n, 32'd4);
    chk("target safe", tgt, 16'h2710);
    rreg(16'h68, oth | 16'h0400);
    u_m.xfer(1'b1, 16'h0001, xs(), k, e, q);
    wait_bf(1'b0, 2);
    wreg(16'h6d, 16'h0000, 1'b0);
    rreg(16'h6d, 16'h0000);
    repeat (20) @(posedge clk);
    #1 chk("off at zero", {31'h0, bf}, 32'h0);
    wreg(16'h6d, 16'h0001, 1'b0);
    wreg(16'h76, 16'h0000, 1'b0);
    repeat (20) @(posedge clk);
    #1 chk("hybrid", {31'h0, bf}, 32'h0);
    chk("target analog", tgt, asp);
    wreg(16'h76, 16'h0002, 1'b1);
    complete_run();
  end
endmodule // bwr_watchdog_bank_test
